// ==== src/i2c_register_slave_port.sv ====
`timescale 1ns/100ps
module i2c_register_slave_port
    import i2c_slave_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic strapped_address_bit,
    output logic four_wire_q,
    output logic wr_pulse_q,
    output logic [PTR_W-1:0] wr_addr_q,
    output logic [REG_W-1:0] wr_data_q,
    output logic [NUM_REGS*REG_W-1:0] regs_q
);

    // two-stage synchronisers; stage one feeds stage two only
    logic scl_m_q, scl_s_q, scl_p_q;
    logic sda_m_q, sda_s_q, sda_p_q;
    logic cs_m_q, cs_s_q, cs_p_q;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
            cs_m_q <= 1'b0;
            cs_s_q <= 1'b0;
            cs_p_q <= 1'b0;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
            cs_m_q <= strapped_address_bit;
            cs_s_q <= cs_m_q;
            cs_p_q <= cs_s_q;
        end
    end

    logic scl_rise, scl_fall, start_ev, stop_ev, cs_rise;
    assign scl_rise = scl_s_q & ~scl_p_q;
    assign scl_fall = ~scl_s_q & scl_p_q;
    assign start_ev = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign stop_ev = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
    assign cs_rise = cs_s_q & ~cs_p_q;

    // four-wire lock: power cycle (reset) is the only way back
    logic [1:0] edges_q, edges_d;
    logic four_wire_d;

    always_comb begin
        edges_d = edges_q;
        four_wire_d = four_wire_q;
        if (cs_rise && !four_wire_q) begin
            edges_d = edges_q + 2'h1;
            if (edges_d == LOCK_EDGES) begin
                four_wire_d = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            edges_q <= EDGE_ZERO;
            four_wire_q <= 1'b0;
        end else begin
            edges_q <= edges_d;
            four_wire_q <= four_wire_d;
        end
    end

    // protocol engine
    slave_state_t st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic nine_q, nine_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] tx_q, tx_d;
    logic dir_q, dir_d;
    logic [PTR_W-1:0] ptr_q, ptr_d;
    logic oe_q, oe_d;
    logic wr_pulse_d;
    logic [PTR_W-1:0] wr_addr_d;
    logic [REG_W-1:0] wr_data_d;
    logic [NUM_REGS*REG_W-1:0] regs_d;
    logic [6:0] own_addr;
    logic addr_match, eval_ev, end_ev;
    logic [PTR_W-1:0] ptr_next;
    logic [REG_W-1:0] rd_byte;

    assign own_addr = {ADDR_FIX_HI, cs_s_q, ADDR_FIX_LO};
    assign addr_match = (sh_q[7:1] == own_addr);
    assign eval_ev = scl_fall && !nine_q && (cnt_q == BITS_PER_BYTE);
    assign end_ev = scl_fall && nine_q;
    // wrapping past the last register keeps bursts inside the bank
    assign ptr_next = (ptr_q == PTR_LAST) ? PTR_RESET : ptr_q + 6'h01;
    assign rd_byte = regs_q[{ptr_q, 3'b000} +: REG_W];

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        nine_d = nine_q;
        sh_d = sh_q;
        tx_d = tx_q;
        dir_d = dir_q;
        ptr_d = ptr_q;
        oe_d = oe_q;
        wr_pulse_d = 1'b0;
        wr_addr_d = wr_addr_q;
        wr_data_d = wr_data_q;
        regs_d = regs_q;
        if (four_wire_q) begin
            st_d = ST_IDLE;
            oe_d = 1'b0;
            nine_d = 1'b0;
            cnt_d = CNT_ZERO;
        end else if (stop_ev) begin
            st_d = ST_IDLE;
            oe_d = 1'b0;
            nine_d = 1'b0;
            cnt_d = CNT_ZERO;
        end else if (start_ev) begin
            // a start in any state, while not four-wire locked, abandons the access and begins a new address phase
            st_d = ST_ADDR;
            oe_d = 1'b0;
            nine_d = 1'b0;
            cnt_d = CNT_ZERO;
        end else if (st_q == ST_IDLE) begin
            oe_d = 1'b0;
        end else if (scl_rise) begin
            if (cnt_q < BITS_PER_BYTE) begin
                sh_d = {sh_q[6:0], sda_s_q};
                cnt_d = cnt_q + CNT_ONE;
            end else begin
                cnt_d = CNT_ZERO;
                nine_d = 1'b1;
                if (st_q == ST_RD && sda_s_q) begin
                    st_d = ST_IDLE;
                end
            end
        end else if (eval_ev) begin
            case (st_q)
                ST_ADDR: begin
                    if (addr_match) begin
                        oe_d = 1'b1;
                        dir_d = sh_q[0];
                    end else begin
                        st_d = ST_IDLE;
                        oe_d = 1'b0;
                    end
                end
                ST_SUB: begin
                    if (sh_q < SUB_LIMIT) begin
                        oe_d = 1'b1;
                        ptr_d = sh_q[PTR_W-1:0];
                    end else begin
                        st_d = ST_IDLE;
                        oe_d = 1'b0;
                    end
                end
                ST_WR: begin
                    oe_d = 1'b1;
                    regs_d[{ptr_q, 3'b000} +: REG_W] = sh_q;
                    wr_pulse_d = 1'b1;
                    wr_addr_d = ptr_q;
                    wr_data_d = sh_q;
                    ptr_d = ptr_next;
                end
                ST_RD: begin
                    oe_d = 1'b0;
                    ptr_d = ptr_next;
                end
                default: begin
                    st_d = ST_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end else if (end_ev) begin
            nine_d = 1'b0;
            oe_d = 1'b0;
            case (st_q)
                ST_ADDR: begin
                    if (dir_q) begin
                        st_d = ST_RD;
                        tx_d = rd_byte;
                        oe_d = ~rd_byte[7];
                    end else begin
                        st_d = ST_SUB;
                    end
                end
                ST_SUB: st_d = ST_WR;
                ST_WR: st_d = ST_WR;
                ST_RD: begin
                    tx_d = rd_byte;
                    oe_d = ~rd_byte[7];
                end
                default: st_d = ST_IDLE;
            endcase
        end else if (scl_fall && st_q == ST_RD && cnt_q != CNT_ZERO) begin
            tx_d = {tx_q[6:0], 1'b0};
            oe_d = ~tx_d[7];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= ST_IDLE;
            cnt_q <= CNT_ZERO;
            nine_q <= 1'b0;
            sh_q <= REG_RESET;
            tx_q <= REG_RESET;
            dir_q <= 1'b0;
            ptr_q <= PTR_RESET;
            oe_q <= 1'b0;
            wr_pulse_q <= 1'b0;
            wr_addr_q <= PTR_RESET;
            wr_data_q <= REG_RESET;
            regs_q <= '0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            nine_q <= nine_d;
            sh_q <= sh_d;
            tx_q <= tx_d;
            dir_q <= dir_d;
            ptr_q <= ptr_d;
            oe_q <= oe_d;
            wr_pulse_q <= wr_pulse_d;
            wr_addr_q <= wr_addr_d;
            wr_data_q <= wr_data_d;
            regs_q <= regs_d;
        end
    end

    // open drain: the pin is only ever pulled low
    assign sda_o = 1'b0;
    assign sda_oe = oe_q;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    logic quiet;
    assign quiet = !four_wire_q && !stop_ev && !start_ev;

    addr_ack_a: assert property (
        quiet && st_q == ST_ADDR && eval_ev && addr_match |=> sda_oe ##1 sda_oe[*2])
        else $error("matching address not acknowledged");

    addr_miss_a: assert property (
        quiet && st_q == ST_ADDR && eval_ev && !addr_match |=> st_q == ST_IDLE && !sda_oe)
        else $error("mismatched address did not release the bus");

    addr_layout_a: assert property (
        $rose(sda_oe) && st_q == ST_ADDR |->
        $past(sh_q[7]) && $past(sh_q[5:1]) == ADDR_FIX_LO
        && $past(sh_q[6]) == $past(cs_s_q))
        else $error("acknowledged an address outside the own pair");

    sub_invalid_a: assert property (
        quiet && st_q == ST_SUB && eval_ev && sh_q >= SUB_LIMIT |=> st_q == ST_IDLE && !sda_oe)
        else $error("invalid subaddress was acknowledged");

    stop_idle_a: assert property (
        stop_ev |=> st_q == ST_IDLE && !sda_oe ##1 st_q == ST_IDLE)
        else $error("stop did not end the access");

    start_addr_a: assert property (
        !four_wire_q && start_ev && !stop_ev |=> st_q == ST_ADDR && cnt_q == CNT_ZERO && !sda_oe)
        else $error("start did not open an address phase");

    write_ptr_a: assert property (
        quiet && st_q == ST_WR && eval_ev |=>
        wr_pulse_q && wr_addr_q == $past(ptr_q) && wr_data_q == $past(sh_q)
        && ptr_q == (($past(ptr_q) == PTR_LAST) ? PTR_RESET : $past(ptr_q) + 6'h01))
        else $error("write not stored or pointer not advanced");

    rd_release_a: assert property (
        quiet && st_q == ST_RD && eval_ev |=> !sda_oe)
        else $error("read did not release the acknowledge slot");

    rd_msb_a: assert property (
        quiet && st_q == ST_ADDR && end_ev && dir_q |=> st_q == ST_RD && sda_oe == ~tx_q[7]
        && tx_q == $past(rd_byte))
        else $error("read byte not started with its top bit");

    lock_hold_a: assert property (
        four_wire_q |=> four_wire_q && !sda_oe && st_q == ST_IDLE)
        else $error("four-wire lock released or two-wire still active");

    write_cov: cover property (st_q == ST_WR && wr_pulse_q);
    read_cov: cover property (st_q == ST_RD && eval_ev);
    nack_cov: cover property (st_q == ST_SUB && eval_ev && sh_q >= SUB_LIMIT);
    lock_cov: cover property ($rose(four_wire_q));

endmodule

// ==== src/i2c_slave_pkg.sv ====
package i2c_slave_pkg;

    // register bank
    localparam int NUM_REGS = 34;
    localparam int REG_W = 8;
    localparam int PTR_W = 6;
    localparam logic [7:0] SUB_LIMIT = 8'h22;
    localparam logic [PTR_W-1:0] PTR_LAST = 6'h21;
    localparam logic [PTR_W-1:0] PTR_RESET = 6'h00;
    localparam logic [REG_W-1:0] REG_RESET = 8'h00;

    // slave address layout: [6] fixed one, [5] strapped, [4:0] fixed zero
    localparam int ADDR_FIX_HI_POS = 6;
    localparam int ADDR_STRAP_POS = 5;
    localparam logic ADDR_FIX_HI = 1'b1;
    localparam logic [4:0] ADDR_FIX_LO = 5'h00;

    // bit counting within one byte
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;

    // chip-select rising edges that lock the four-wire mode
    localparam logic [1:0] LOCK_EDGES = 2'h3;
    localparam logic [1:0] EDGE_ZERO = 2'h0;

    // link clock period seen in the bench and the system clock period
    localparam int LINK_PERIOD_NS = 400;
    localparam int CLK_PERIOD_NS = 50;
    localparam int LINK_CYCLES = (LINK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_SUB,
        ST_WR,
        ST_RD
    } slave_state_t;

endpackage

// ==== sim/i2c_bus_master.sv ====
`timescale 1ns/100ps
module i2c_bus_master (
    input wire logic ref_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // clock stands high between frames; low phase 5 clocks so the slave's
    // turnaround (up to 4 clocks after the fall) settles before the rise
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // also a repeated start when the clock is low
    task automatic start();
        sda_low = 1'b0;
        w(5);
        scl = 1'b1;
        w(3);
        sda_low = 1'b1;
        w(3);
        scl = 1'b0;
    endtask
    task automatic stop();
        sda_low = 1'b1;
        w(5);
        scl = 1'b1;
        w(3);
        sda_low = 1'b0;
        w(3);
    endtask
    task automatic bit_io(input logic b, output logic seen);
        sda_low = ~b;
        w(5);
        scl = 1'b1;
        w(3);
        seen = sda;
        scl = 1'b0;
    endtask
    // mack pulls the ninth slot low, as a reading master does
    task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                        output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(~mack, s);
        ack = ~s;
    endtask
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
    import i2c_slave_pkg::*;
    typedef struct {logic [7:0] sub; logic [7:0] data;} row_t;
    logic ref_clk, rstn, strapped_address_bit, scl, sda_low, sda;
    logic sda_o, sda_oe, four_wire_q, wr_pulse_q;
    logic [PTR_W-1:0] wr_addr_q;
    logic [REG_W-1:0] wr_data_q;
    logic [NUM_REGS*REG_W-1:0] regs_q;
    int mismatches = 0, num_checks = 0, pulses = 0, p0;
    logic [6:0] dev;
    logic [7:0] rx;
    logic ack;
    logic [7:0] q[$];
    row_t rows[3] = '{'{8'h00, 8'hA5}, '{8'h21, 8'h3C}, '{8'h10, 8'h81}};

    // pull-up on the data line
    assign sda = (sda_low || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    i2c_register_slave_port dut (.ref_clk(ref_clk), .rstn(rstn), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .strapped_address_bit(strapped_address_bit),
        .four_wire_q(four_wire_q), .wr_pulse_q(wr_pulse_q), .wr_addr_q(wr_addr_q),
        .wr_data_q(wr_data_q), .regs_q(regs_q));
    i2c_bus_master m (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(sda_low));

    always @(posedge ref_clk) begin
        if (wr_pulse_q === 1'b1) begin
            pulses++;
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic addr_phase(input logic [7:0] sub);
        m.start();
        m.xfer({dev, 1'b0}, 1'b0, rx, ack);
        check("address ack", ack, 1'b1);
        m.xfer(sub, 1'b0, rx, ack);
    endtask
    task automatic wr(input logic [7:0] sub, input logic [7:0] d[$]);
        addr_phase(sub);
        check("sub ack", ack, 1'b1);
        foreach (d[i]) begin
            m.xfer(d[i], 1'b0, rx, ack);
            check("data ack", ack, 1'b1);
        end
        m.stop();
    endtask
    task automatic rd(input logic [7:0] sub, input int n);
        addr_phase(sub);
        m.start();
        m.xfer({dev, 1'b1}, 1'b0, rx, ack);
        check("read address ack", ack, 1'b1);
        q = {};
        for (int i = 0; i < n; i++) begin
            m.xfer(8'hFF, (i < n - 1) ? 1'b1 : 1'b0, rx, ack);
            q.push_back(rx);
        end
        m.stop();
    endtask
    task automatic probe(input logic [7:0] b, input logic exp);
        m.start();
        m.xfer(b, 1'b0, rx, ack);
        m.stop();
        check("probe ack", ack, exp);
    endtask
    task automatic strap(input logic v);
        strapped_address_bit = v;
        m.w(4);
    endtask

    initial begin
        repeat (100000) @(posedge ref_clk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        rstn = 1'b0;
        strapped_address_bit = 1'b0;
        dev = 7'h40;
        m.w(5);
        rstn = 1'b1;
        check("idle line", sda_oe, 1'b0);
        check("bank reset", regs_q[31:0], 32'h0);
        check("open drain value", sda_o, 1'b0);
        m.w(4);
        foreach (rows[i]) begin
            wr(rows[i].sub, {rows[i].data});
            check("written reg", regs_q[8*rows[i].sub +: 8], rows[i].data);
            check("write index", wr_addr_q, rows[i].sub);
            check("write data", wr_data_q, rows[i].data);
            rd(rows[i].sub, 1);
            check("read back", q[0], rows[i].data);
        end
        // burst across the top of the bank wraps to the first register
        p0 = pulses;
        wr(8'h20, {8'h11, 8'h22, 8'h33});
        check("burst pulses", pulses - p0, 3);
        check("reg 20", regs_q[8*32 +: 8], 8'h11);
        check("reg 21", regs_q[8*33 +: 8], 8'h22);
        check("reg 0", regs_q[7:0], 8'h33);
        rd(8'h21, 2);
        check("burst rd 21", q[0], 8'h22);
        check("burst rd 0", q[1], 8'h33);
        p0 = pulses;
        addr_phase(8'h22);
        check("bad sub nack", ack, 1'b0);
        m.xfer(8'h5A, 1'b0, rx, ack);
        check("idle after bad sub", ack, 1'b0);
        m.stop();
        check("no write", pulses - p0, 0);
        probe(8'hC0, 1'b0);
        probe(8'h82, 1'b0);
        probe(8'h00, 1'b0);
        addr_phase(8'h05);
        for (int i = 0; i < 4; i++) begin
            m.bit_io(1'b1, ack);
        end
        wr(8'h06, {8'hC3});
        check("aborted byte", regs_q[8*5 +: 8], 8'h00);
        check("after abort", regs_q[8*6 +: 8], 8'hC3);
        strap(1'b1);
        dev = 7'h60;
        probe(8'h80, 1'b0);
        wr(8'h07, {8'h5A});
        check("strapped write", regs_q[8*7 +: 8], 8'h5A);
        check("not locked", four_wire_q, 1'b0);
        repeat (2) begin
            strap(1'b0);
            strap(1'b1);
        end
        check("locked", four_wire_q, 1'b1);
        probe(8'hC0, 1'b0);
        rstn = 1'b0;
        m.w(2);
        check("unlocked by reset", four_wire_q, 1'b0);
        report_and_stop();
    end
endmodule
